// File: inc/imr_pkg.sv
// ----------------------------------------
// shared constants
// ----------------------------------------
package imr_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam logic [3:0] TYPE_CODE = 4'hA;
  localparam logic [4:0] HS_CODE = 5'h01;
  localparam logic [7:0] HS_ENTRY = 8'h08;
  localparam logic [7:0] RSVD_ID = 8'hF8;
  localparam logic [7:0] SLEEP_CMD = 8'h86;
  localparam logic [7:0] ID_CMD = 8'hF9;
  localparam logic [1:0] ID_LAST = 2'h2;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam int unsigned SYNC_LEN = 3;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_KHZ = 250000;
  localparam int unsigned CLK_PS = 4000;
  localparam int unsigned STD_KHZ = 400;
  localparam int unsigned HS_KHZ = 3400;
  // scl rates are maxima, so each quarter period rounds up
  localparam int unsigned STD_Q_CYC = (CLK_KHZ + 4 * STD_KHZ - 1) / (4 * STD_KHZ);
  localparam int unsigned HS_Q_CYC = (CLK_KHZ + 4 * HS_KHZ - 1) / (4 * HS_KHZ);
  localparam int unsigned REC_NS = 1000;
  localparam int unsigned REC_CYC = (REC_NS * 1000 + CLK_PS - 1) / CLK_PS;
  // ----------------------------------------
  // master items and commands
  // ----------------------------------------
  localparam logic [1:0] IT_START = 2'h0;
  localparam logic [1:0] IT_WR = 2'h1;
  localparam logic [1:0] IT_RD = 2'h2;
  localparam logic [1:0] IT_STOP = 2'h3;
  typedef enum logic [1:0] {
    CMD_READ = 2'h0,
    CMD_ID = 2'h1,
    CMD_SLEEP = 2'h2,
    CMD_WAKE = 2'h3
  } imr_cmd_type;
endpackage

// File: inc/imr_link_if.sv
`timescale 1ns/1ps
// ----------------------------------------
// two-wire link, sda is open drain with pull-up
// ----------------------------------------
interface imr_link_if;
  logic scl;
  logic sda;
  logic sda_m_out;
  logic sda_m_oe;
  logic sda_d_out;
  logic sda_d_oe;
  // wired-and of both open drain drivers
  assign sda = !((sda_m_oe && !sda_m_out) || (sda_d_oe && !sda_d_out));
  modport master (output scl, output sda_m_out, output sda_m_oe, input sda);
  modport device (input scl, input sda, output sda_d_out, output sda_d_oe);
endinterface

// File: hdl/imr_device.sv
`timescale 1ns/1ps
// Notes on behaviour
// [R1] random read: address write, restart, read
// [R2] master nacks last byte, then stops
// [R3] keep sending while master acknowledges
// [R4] read address wraps to zero
// [R5] high speed entry code is 00001xxx
// [R6] entry code is never acknowledged
// [R7] after entry nack, faster scl allowed
// [R8] stop ends high speed operation
// [R9] sleep: F8h acked, then address word
// [R10] master restarts and sends 86h
// [R11] ack 86h, then enter sleep
// [R12] asleep watches bus; start plus address wakes
// [R13] ninth scl rise starts regulator restart
// [R14] standby only after recovery time
// [R15] fixed three byte identification value
// [R16] id: F8h acked, then address word
// [R17] restart, F9h acked, id bytes follow
// [R18] id bytes sent first, second, third
// [R19] ack after third byte restarts id
// [R20] id is maker field then product field
// [R21] match type code and select pins
// [R22] two address bytes, high first, acked
// [R23] asleep or recovering: ignore other traffic
module imr_device #(
  parameter int unsigned AW = imr_pkg::ADDR_W,
  parameter int unsigned REC_CYCLES = imr_pkg::REC_CYC,
  parameter logic [11:0] MAKER_ID = 12'h3C1, // arbitrary value
  parameter logic [3:0] DENSITY = 4'h5, // arbitrary value
  parameter logic [7:0] PART_CODE = 8'h27 // arbitrary value
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic addr_select_pin_2,
  input wire logic addr_select_pin_1,
  input wire logic addr_select_pin_0,
  input wire logic mem_wr_en,
  input wire logic [AW-1:0] mem_wr_addr,
  input wire logic [7:0] mem_wr_data,
  output logic asleep,
  output logic hs_active,
  imr_link_if.device link
);
  import imr_pkg::*;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01, ST_RX = 8'h02, ST_ACK = 8'h04, ST_TX = 8'h08,
    ST_MACK = 8'h10, ST_SLEEP = 8'h20, ST_WAKE = 8'h40, ST_REC = 8'h80
  } imr_state_type;
  typedef enum logic [4:0] {
    PH_FIRST = 5'h01, PH_RSVD = 5'h02, PH_ADRH = 5'h04, PH_ADRL = 5'h08, PH_DATA = 5'h10
  } imr_phase_type;

  // ----------------------------------------
  // memory, loaded from the user side
  // ----------------------------------------
  logic [7:0] mem [2**AW];
  // a load racing a bus read of the same word may return either value
  always_ff @(posedge clk)
  begin
    if (mem_wr_en)
      mem[mem_wr_addr] <= mem_wr_data;
  end

  // ----------------------------------------
  // link domain reset and input sampling
  // ----------------------------------------
  logic [1:0] lrst_q;
  logic lrst;
  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
      lrst_q <= 2'h3;
    else
      lrst_q <= {lrst_q[0], 1'b0};
  end
  assign lrst = lrst_q[1];

  logic rec_rdy;
  logic [5:0] in_raw, s1, s2, s3, filt;
  assign in_raw = {rec_rdy, addr_select_pin_2, addr_select_pin_1, addr_select_pin_0, link.sda, link.scl};
  always_ff @(posedge link_clk or posedge lrst)
  begin
    if (lrst)
    begin
      s1 <= 6'h1F;
      s2 <= 6'h1F;
      s3 <= 6'h1F;
    end
    else
    begin
      s1 <= in_raw;
      s2 <= s1;
      s3 <= s2;
    end
  end
  for (genvar i = 0; i < 6; i++)
  begin : g_lfilt
    always_ff @(posedge link_clk or posedge lrst)
    begin
      if (lrst)
        filt[i] <= (i < 5);
      else if (s2[i] == s3[i])
        filt[i] <= s3[i];
    end
  end

  logic scl_d, sda_d, scl_rise, scl_fall, start_c, stop_c;
  logic [2:0] pins;
  always_ff @(posedge link_clk or posedge lrst)
  begin
    if (lrst)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= filt[0];
      sda_d <= filt[1];
    end
  end
  assign scl_rise = filt[0] && !scl_d;
  assign scl_fall = !filt[0] && scl_d;
  assign start_c = filt[0] && scl_d && sda_d && !filt[1];
  assign stop_c = filt[0] && scl_d && !sda_d && filt[1];
  assign pins = filt[4:2];

  // ----------------------------------------
  // byte decode
  // ----------------------------------------
  imr_state_type st;
  imr_phase_type ph, next_ph;
  logic [3:0] bit_cnt;
  logic [7:0] shreg, addr_hi, tx_byte;
  logic [AW-1:0] rd_addr;
  logic [1:0] id_idx;
  logic [23:0] id_word;
  logic oe, pend, go_tx, go_sleep, id_mode, rec_req, hs, asleep_l;
  logic dev_hit, dec_ack, dec_tx, dec_id, dec_sleep, dec_hs, dec_pend;

  assign id_word = {MAKER_ID, DENSITY, PART_CODE}; // [R15] [R20]

  always_comb
  begin
    dev_hit = (shreg[7:4] == TYPE_CODE) && (shreg[3:1] == pins); // [R21]
    dec_ack = 1'b0;
    dec_tx = 1'b0;
    dec_id = 1'b0;
    dec_sleep = 1'b0;
    dec_hs = 1'b0;
    dec_pend = pend;
    next_ph = ph;
    unique case (ph)
      PH_FIRST:
      begin
        dec_pend = 1'b0;
        if (shreg[7:3] == HS_CODE)
          dec_hs = 1'b1; // [R5] [R6]
        else if (shreg == RSVD_ID)
        begin
          dec_ack = 1'b1; // [R9] [R16]
          next_ph = PH_RSVD;
        end
        else if (pend && shreg == SLEEP_CMD)
        begin
          dec_ack = 1'b1; // [R10] [R11]
          dec_sleep = 1'b1;
        end
        else if (pend && shreg == ID_CMD)
        begin
          dec_ack = 1'b1; // [R17]
          dec_tx = 1'b1;
          dec_id = 1'b1;
        end
        else if (dev_hit)
        begin
          dec_ack = 1'b1;
          dec_tx = shreg[0]; // [R1]
          next_ph = shreg[0] ? PH_FIRST : PH_ADRH;
        end
      end
      PH_RSVD:
      begin
        dec_ack = dev_hit; // [R9] [R16]
        dec_pend = dev_hit;
        next_ph = PH_DATA;
      end
      PH_ADRH:
      begin
        dec_ack = 1'b1; // [R22]
        next_ph = PH_ADRL;
      end
      PH_ADRL:
      begin
        dec_ack = 1'b1; // [R22]
        next_ph = PH_DATA;
      end
      PH_DATA:
        dec_ack = 1'b1;
    endcase
  end

  always_comb
  begin
    tx_byte = mem[rd_addr];
    if (id_mode)
    begin
      unique case (id_idx) // [R18]
        2'h0: tx_byte = id_word[23:16];
        2'h1: tx_byte = id_word[15:8];
        default: tx_byte = id_word[7:0];
      endcase
    end
  end

  // ----------------------------------------
  // bus sequencer
  // ----------------------------------------
  always_ff @(posedge link_clk or posedge lrst)
  begin
    if (lrst)
    begin
      st <= ST_IDLE;
      ph <= PH_FIRST;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      addr_hi <= 8'h00;
      rd_addr <= '0;
      id_idx <= 2'h0;
      oe <= 1'b0;
      pend <= 1'b0;
      go_tx <= 1'b0;
      go_sleep <= 1'b0;
      id_mode <= 1'b0;
      rec_req <= 1'b0;
      hs <= 1'b0;
    end
    else if (stop_c)
    begin
      oe <= 1'b0;
      pend <= 1'b0;
      hs <= 1'b0; // [R8]
      if (st == ST_WAKE)
        st <= ST_SLEEP;
      else if (st != ST_SLEEP && st != ST_REC)
        st <= ST_IDLE;
    end
    else if (start_c)
    begin
      oe <= 1'b0;
      bit_cnt <= 4'h0;
      if (st == ST_SLEEP || st == ST_WAKE)
        st <= ST_WAKE; // [R12] [R23]
      else if (st != ST_REC)
      begin
        st <= ST_RX;
        ph <= PH_FIRST;
      end
    end
    else
    begin
      unique case (st)
        ST_IDLE, ST_SLEEP:
        begin
        end
        ST_RX:
          if (scl_rise)
          begin
            shreg <= {shreg[6:0], filt[1]};
            bit_cnt <= bit_cnt + 4'h1;
          end
          else if (scl_fall && bit_cnt == BIT_ACK)
          begin
            ph <= next_ph;
            pend <= dec_pend;
            go_tx <= dec_tx;
            go_sleep <= dec_sleep;
            if (dec_hs)
              hs <= 1'b1; // [R7]
            if (dec_tx)
            begin
              id_mode <= dec_id;
              id_idx <= 2'h0;
            end
            if (ph == PH_ADRH)
              addr_hi <= shreg;
            if (ph == PH_ADRL)
              rd_addr <= AW'({addr_hi, shreg}); // [R1]
            oe <= dec_ack;
            st <= dec_ack ? ST_ACK : ST_IDLE;
          end
        ST_ACK:
          if (scl_fall)
          begin
            bit_cnt <= 4'h0;
            if (go_sleep)
            begin
              oe <= 1'b0;
              st <= ST_SLEEP; // [R11]
            end
            else if (go_tx)
            begin
              shreg <= tx_byte;
              oe <= !tx_byte[7];
              st <= ST_TX;
            end
            else
            begin
              oe <= 1'b0;
              st <= ST_RX;
            end
          end
        ST_TX:
          if (scl_rise)
            bit_cnt <= bit_cnt + 4'h1;
          else if (scl_fall)
          begin
            if (bit_cnt == BIT_ACK)
            begin
              oe <= 1'b0;
              st <= ST_MACK;
            end
            else
            begin
              oe <= !shreg[6];
              shreg <= {shreg[6:0], 1'b0};
            end
          end
        ST_MACK:
          if (scl_rise)
          begin
            if (id_mode)
              id_idx <= (id_idx == ID_LAST) ? 2'h0 : id_idx + 2'h1; // [R19]
            else
              rd_addr <= rd_addr + 1'b1; // [R4]
            if (filt[1])
              st <= ST_IDLE; // [R2]
          end
          else if (scl_fall)
          begin
            bit_cnt <= 4'h0;
            shreg <= tx_byte; // [R3]
            oe <= !tx_byte[7];
            st <= ST_TX;
          end
        ST_WAKE:
          if (scl_rise)
          begin
            if (bit_cnt == BIT_ACK)
            begin
              rec_req <= dev_hit; // [R13]
              st <= dev_hit ? ST_REC : ST_SLEEP;
            end
            else
            begin
              shreg <= {shreg[6:0], filt[1]};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        ST_REC:
          if (filt[5])
          begin
            rec_req <= 1'b0; // [R14]
            st <= ST_IDLE;
          end
      endcase
    end
  end

  always_ff @(posedge link_clk or posedge lrst)
  begin
    if (lrst)
      asleep_l <= 1'b0;
    else
      asleep_l <= (st == ST_SLEEP) || (st == ST_WAKE) || (st == ST_REC);
  end

  assign link.sda_d_oe = oe;
  assign link.sda_d_out = 1'b0;

  // ----------------------------------------
  // user domain: status and regulator recovery
  // ----------------------------------------
  logic [2:0] c_raw, c1, c2, c3, cfilt;
  logic [$clog2(REC_CYCLES+1)-1:0] rec_cnt;
  assign c_raw = {hs, asleep_l, rec_req};
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      c1 <= 3'h0;
      c2 <= 3'h0;
      c3 <= 3'h0;
    end
    else
    begin
      c1 <= c_raw;
      c2 <= c1;
      c3 <= c2;
    end
  end
  for (genvar i = 0; i < 3; i++)
  begin : g_cfilt
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
        cfilt[i] <= 1'b0;
      else if (c2[i] == c3[i])
        cfilt[i] <= c3[i];
    end
  end
  assign asleep = cfilt[1];
  assign hs_active = cfilt[2];

  // four-phase handshake: ready drops only after the request drops
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rec_cnt <= '0;
      rec_rdy <= 1'b0;
    end
    else if (!cfilt[0])
    begin
      rec_cnt <= '0;
      rec_rdy <= 1'b0;
    end
    else if (rec_cnt == $bits(rec_cnt)'(REC_CYCLES - 1))
      rec_rdy <= 1'b1; // [R14]
    else
      rec_cnt <= rec_cnt + 1'b1;
  end
endmodule // imr_device

// File: hdl/imr_master.sv
`timescale 1ns/1ps
module imr_master #(
  parameter int unsigned STD_Q = imr_pkg::STD_Q_CYC,
  parameter int unsigned HS_Q = imr_pkg::HS_Q_CYC
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire imr_pkg::imr_cmd_type cmd_kind,
  input wire logic cmd_hs,
  input wire logic [2:0] cmd_dev,
  input wire logic [15:0] cmd_addr,
  input wire logic [7:0] cmd_len,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic done,
  output logic nack_seen,
  imr_link_if.master link
);
  import imr_pkg::*;

  typedef enum logic [2:0] {M_IDLE = 3'h1, M_LOAD = 3'h2, M_RUN = 3'h4} imr_mstate_type;

  // ----------------------------------------
  // command scripts
  // ----------------------------------------
  function automatic logic [9:0] item_at(imr_cmd_type k, logic [3:0] s, logic [2:0] dv, logic [15:0] a);
    logic [7:0] dw;
    dw = {TYPE_CODE, dv, 1'b0};
    item_at = {IT_STOP, 8'h00};
    unique case (k)
      CMD_READ: // [R1] [R22]
        case (s)
          4'h0, 4'h4: item_at = {IT_START, 8'h00};
          4'h1: item_at = {IT_WR, dw};
          4'h2: item_at = {IT_WR, a[15:8]};
          4'h3: item_at = {IT_WR, a[7:0]};
          4'h5: item_at = {IT_WR, dw | 8'h01};
          4'h6: item_at = {IT_RD, 8'h00};
          default: item_at = {IT_STOP, 8'h00};
        endcase
      CMD_ID, CMD_SLEEP: // [R9] [R10] [R16] [R17]
        case (s)
          4'h0, 4'h3: item_at = {IT_START, 8'h00};
          4'h1: item_at = {IT_WR, RSVD_ID};
          4'h2: item_at = {IT_WR, dw};
          4'h4: item_at = {IT_WR, (k == CMD_ID) ? ID_CMD : SLEEP_CMD};
          4'h5: item_at = (k == CMD_ID) ? {IT_RD, 8'h00} : {IT_STOP, 8'h00};
          default: item_at = {IT_STOP, 8'h00};
        endcase
      CMD_WAKE: // [R12]
        case (s)
          4'h0: item_at = {IT_START, 8'h00};
          4'h1: item_at = {IT_WR, dw};
          default: item_at = {IT_STOP, 8'h00};
        endcase
    endcase
  endfunction

  // ----------------------------------------
  // sda sampling
  // ----------------------------------------
  logic s1, s2, s3, sda_s;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      sda_s <= 1'b1;
    end
    else
    begin
      s1 <= link.sda;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        sda_s <= s3;
    end
  end

  // ----------------------------------------
  // bit engine, four quarters per scl period
  // ----------------------------------------
  imr_mstate_type st;
  imr_cmd_type kind;
  logic hs_pre, hs_on, scl_q, oe_q, tick;
  logic [2:0] dev;
  logic [15:0] addr, qcnt;
  logic [7:0] left, sh;
  logic [3:0] step, bi;
  logic [1:0] it, qc;
  logic [9:0] item;

  always_comb
  begin
    if (hs_pre && step < 4'h2)
      item = (step == 4'h0) ? {IT_START, 8'h00} : {IT_WR, HS_ENTRY}; // [R5]
    else
      item = item_at(kind, step - (hs_pre ? 4'h2 : 4'h0), dev, addr);
  end
  assign tick = qcnt == (hs_on ? 16'(HS_Q - 1) : 16'(STD_Q - 1)); // [R7]

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st <= M_IDLE;
      kind <= CMD_READ;
      hs_pre <= 1'b0;
      hs_on <= 1'b0;
      dev <= 3'h0;
      addr <= 16'h0000;
      left <= 8'h01;
      step <= 4'h0;
      it <= IT_STOP;
      sh <= 8'h00;
      bi <= 4'h0;
      qc <= 2'h0;
      qcnt <= 16'h0000;
      scl_q <= 1'b1;
      oe_q <= 1'b0;
      cmd_ready <= 1'b1;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      done <= 1'b0;
      nack_seen <= 1'b0;
    end
    else
    begin
      rd_valid <= 1'b0;
      done <= 1'b0;
      unique case (st)
        M_IDLE:
          if (cmd_valid)
          begin
            kind <= cmd_kind;
            hs_pre <= cmd_hs;
            dev <= cmd_dev;
            addr <= cmd_addr;
            left <= (cmd_kind == CMD_ID) ? 8'h03 : ((cmd_len == 8'h00) ? 8'h01 : cmd_len);
            step <= 4'h0;
            nack_seen <= 1'b0;
            cmd_ready <= 1'b0;
            st <= M_LOAD;
          end
        M_LOAD:
        begin
          it <= item[9:8];
          sh <= item[7:0];
          bi <= 4'h0;
          qc <= 2'h0;
          qcnt <= 16'h0000;
          st <= M_RUN;
        end
        M_RUN:
          if (!tick)
            qcnt <= qcnt + 16'h0001;
          else
          begin
            qcnt <= 16'h0000;
            qc <= qc + 2'h1;
            unique case (qc)
              2'h0:
                unique case (it)
                  IT_START: oe_q <= 1'b0;
                  IT_STOP: oe_q <= 1'b1;
                  IT_WR: oe_q <= (bi == BIT_ACK) ? 1'b0 : !sh[7];
                  IT_RD: oe_q <= (bi == BIT_ACK) && (left != 8'h01); // [R2] [R3] [R19]
                endcase
              2'h1:
                scl_q <= 1'b1;
              2'h2:
                if (it == IT_START)
                  oe_q <= 1'b1;
                else if (it == IT_STOP)
                  oe_q <= 1'b0; // [R2]
                else if (bi != BIT_ACK)
                  sh <= {sh[6:0], sda_s};
                else if (it == IT_WR && sda_s && !(hs_pre && step == 4'h1))
                  nack_seen <= 1'b1;
              2'h3:
                if (it == IT_STOP)
                begin
                  hs_on <= 1'b0; // [R8]
                  done <= 1'b1;
                  cmd_ready <= 1'b1;
                  st <= M_IDLE;
                end
                else
                begin
                  scl_q <= 1'b0;
                  if (it == IT_START || bi == BIT_ACK)
                  begin
                    st <= M_LOAD;
                    if (it == IT_WR && hs_pre && step == 4'h1)
                      hs_on <= 1'b1; // [R7]
                    if (it == IT_RD)
                    begin
                      rd_data <= sh;
                      rd_valid <= 1'b1;
                      left <= left - 8'h01;
                      if (left == 8'h01)
                        step <= step + 4'h1;
                    end
                    else
                      step <= step + 4'h1;
                  end
                  else
                    bi <= bi + 4'h1;
                end
            endcase
          end
        default:
          st <= M_IDLE;
      endcase
    end
  end

  assign link.scl = scl_q;
  assign link.sda_m_oe = oe_q;
  assign link.sda_m_out = 1'b0;
endmodule // imr_master

// File: test/imr_checker.sv
`timescale 1ns/1ps
// ----------------------------------------
// wire checks beside the link
// ----------------------------------------
module imr_checker
  import imr_pkg::*;
(
  input wire logic link_clk,
  input wire logic rst,
  input wire logic [2:0] sel,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_m_out,
  input wire logic sda_m_oe,
  input wire logic sda_d_out,
  input wire logic sda_d_oe
);
  logic scl_q;
  logic sda_q;
  logic first;
  logic [3:0] nb;
  logic [7:0] sh;
  wire rise = scl && !scl_q;
  wire start = scl && scl_q && sda_q && !sda;
  wire stop = scl && scl_q && !sda_q && sda;
  wire ack = rise && nb == 4'h8;
  always_ff @(posedge link_clk or posedge rst)
    if (rst)
    begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
    end
  // a repeated start after a stray rise resets the count, so no byte is misaligned
  always_ff @(posedge link_clk or posedge rst)
    if (rst)
    begin
      nb <= 4'h0;
      first <= 1'h0;
    end
    else if (start)
    begin
      nb <= 4'h0;
      first <= 1'h1;
    end
    else if (ack)
    begin
      nb <= 4'h0;
      first <= 1'h0;
    end
    else if (rise)
      nb <= nb + 4'h1;
  always_ff @(posedge link_clk or posedge rst)
    if (rst)
      sh <= 8'h00;
    else if (rise && !ack)
      sh <= {sh[6:0], sda};
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (rst);
  property p_stable_high;
    scl && scl_q |-> $stable(sda_d_oe);
  endproperty
  a_stable_high: assert property (p_stable_high) else $error("device moved sda while scl high");
  property p_hold;
    $rose(sda_d_oe) |=> sda_d_oe [*4];
  endproperty
  a_hold: assert property (p_hold) else $error("device low drive too short");
  property p_hs_nack;
    ack && first && sh[7:3] == HS_CODE |-> sda;
  endproperty
  a_hs_nack: assert property (p_hs_nack) else $error("entry code acknowledged");
  property p_sel_nack;
    ack && first && sh[7:4] == TYPE_CODE && sh[3:1] != sel |-> sda && !sda_d_oe;
  endproperty
  a_sel_nack: assert property (p_sel_nack) else $error("foreign address acknowledged");
  property p_rsvd_ack;
    ack && first && sh == RSVD_ID |-> !sda && !sda_m_oe;
  endproperty
  a_rsvd_ack: assert property (p_rsvd_ack) else $error("reserved byte not acknowledged");
  property p_id_ack;
    ack && first && sh == ID_CMD |-> sda_d_oe ##1 sda_d_oe;
  endproperty
  a_id_ack: assert property (p_id_ack) else $error("id command not acknowledged");
  property p_sleep_ack;
    ack && first && sh == SLEEP_CMD |-> !sda;
  endproperty
  a_sleep_ack: assert property (p_sleep_ack) else $error("sleep command not acknowledged");
  property p_listen;
    first && rise && nb != 4'h8 |-> !sda_d_oe;
  endproperty
  a_listen: assert property (p_listen) else $error("device drove sda in address byte");
  property p_stop_release;
    stop |-> !sda_d_oe [*3];
  endproperty
  a_stop_release: assert property (p_stop_release) else $error("device drove sda after stop");
endmodule // imr_checker

// File: test/testbench.sv
`timescale 1ns/1ps
// ----------------------------------------
// both ends face to face, driven from the user sides
// ----------------------------------------
module testbench;
  import imr_pkg::*;
  localparam logic [11:0] ID_MK = 12'h3C1; // arbitrary value
  localparam logic [3:0] ID_DN = 4'h5; // arbitrary value
  localparam logic [7:0] ID_PC = 8'h27; // arbitrary value
  localparam logic [23:0] ID_ALL = {ID_MK, ID_DN, ID_PC};
  logic clk = 1'h0;
  logic link_clk = 1'h0;
  logic rst = 1'h1;
  logic cmd_valid = 1'h0;
  logic cmd_ready;
  imr_cmd_type cmd_kind = CMD_READ;
  logic cmd_hs = 1'h0;
  logic [2:0] cmd_dev = 3'h5;
  logic [2:0] sel = 3'h5;
  logic [15:0] cmd_addr = 16'h0000;
  logic [7:0] cmd_len = 8'h01;
  logic [7:0] rd_data;
  logic rd_valid;
  logic done;
  logic nack_seen;
  logic mem_wr_en = 1'h0;
  logic [15:0] mem_wr_addr = 16'h0000;
  logic [7:0] mem_wr_data = 8'h00;
  logic asleep;
  logic hs_active;
  logic hs_seen = 1'h0;
  int err_total = 0;
  int n_checks = 0;
  logic [7:0] got[$];
  imr_link_if link();
  always #2 clk = !clk;
  always #15 link_clk = !link_clk;
  always @(posedge clk)
    if (hs_active === 1'h1)
      hs_seen <= 1'h1;
  // standard quarter shortened to keep the run short, still well above link sampling
  imr_master #(.STD_Q(40)) u_imr_master (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_kind(cmd_kind), .cmd_hs(cmd_hs), .cmd_dev(cmd_dev), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
    .rd_data(rd_data), .rd_valid(rd_valid), .done(done), .nack_seen(nack_seen), .link(link));
  imr_device #(.REC_CYCLES(8), .MAKER_ID(ID_MK), .DENSITY(ID_DN), .PART_CODE(ID_PC)) u_imr_device (.clk(clk),
    .rst(rst), .link_clk(link_clk), .addr_select_pin_2(sel[2]), .addr_select_pin_1(sel[1]),
    .addr_select_pin_0(sel[0]),
    .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .asleep(asleep),
    .hs_active(hs_active), .link(link));
  imr_checker u_imr_checker (.link_clk(link_clk), .rst(rst), .sel(sel), .scl(link.scl), .sda(link.sda),
    .sda_m_out(link.sda_m_out), .sda_m_oe(link.sda_m_oe), .sda_d_out(link.sda_d_out), .sda_d_oe(link.sda_d_oe));
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[15:8] ^ a[7:0] ^ 8'h5A;
  endfunction
  task automatic stop_test();
    if (err_total == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic load(input logic [15:0] a);
    @(posedge clk);
    #1;
    mem_wr_en = 1'h1;
    mem_wr_addr = a;
    mem_wr_data = pat(a);
    @(posedge clk);
    #1;
    mem_wr_en = 1'h0;
  endtask
  task automatic run(input imr_cmd_type k, input logic hs, input logic [2:0] dev, input logic [15:0] a,
    input logic [7:0] n);
    int i;
    got = {};
    @(posedge clk);
    #1;
    cmd_kind = k;
    cmd_hs = hs;
    cmd_dev = dev;
    cmd_addr = a;
    cmd_len = n;
    cmd_valid = 1'h1;
    @(posedge clk);
    #1;
    cmd_valid = 1'h0;
    for (i = 0; i < 60000 && done !== 1'h1; i++)
    begin
      @(posedge clk);
      #1;
      if (rd_valid === 1'h1)
        got.push_back(rd_data);
    end
    if (done !== 1'h1)
    begin
      err_total++;
      stop_test();
    end
  endtask
  task automatic wait_sleep(input logic exp);
    int i;
    for (i = 0; i < 400 && asleep !== exp; i++)
    begin
      @(posedge clk);
      #1;
    end
    check({7'h00, asleep}, {7'h00, exp});
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    #1;
    rst = 1'h0;
    repeat (50) @(posedge clk);
    load(16'h1234);
    load(16'hFFFE);
    load(16'hFFFF);
    load(16'h0000);
    load(16'h0001);
    run(CMD_READ, 1'h0, 3'h5, 16'h1234, 8'h01);
    check(8'(got.size()), 8'h01);
    check(got[0], pat(16'h1234));
    check({7'h00, nack_seen}, 8'h00);
    check({7'h00, cmd_ready}, 8'h01);
    run(CMD_READ, 1'h1, 3'h5, 16'hFFFE, 8'h04);
    check(8'(got.size()), 8'h04);
    for (int j = 0; j < 4; j++)
      check(got[j], pat(16'hFFFE + 16'(j)));
    check({7'h00, hs_seen}, 8'h01);
    run(CMD_ID, 1'h0, 3'h5, 16'h0000, 8'h03);
    check({7'h00, hs_active}, 8'h00);
    check(8'(got.size()), 8'h03);
    for (int j = 0; j < 3; j++)
      check(got[j], ID_ALL[23 - 8 * j -: 8]);
    run(CMD_READ, 1'h0, 3'h2, 16'h1234, 8'h01);
    check({7'h00, nack_seen}, 8'h01);
    sel = 3'h2;
    run(CMD_READ, 1'h0, 3'h2, 16'h1234, 8'h01);
    check({7'h00, nack_seen}, 8'h00);
    check(got[0], pat(16'h1234));
    sel = 3'h5;
    run(CMD_SLEEP, 1'h0, 3'h5, 16'h0000, 8'h01);
    wait_sleep(1'h1);
    check({7'h00, nack_seen}, 8'h00);
    // a matching address word is itself a wake request, so probe with a foreign one
    run(CMD_READ, 1'h0, 3'h2, 16'h1234, 8'h01);
    check({7'h00, nack_seen}, 8'h01);
    check({7'h00, asleep}, 8'h01);
    run(CMD_WAKE, 1'h0, 3'h5, 16'h0000, 8'h01);
    wait_sleep(1'h0);
    run(CMD_READ, 1'h0, 3'h5, 16'h0001, 8'h01);
    check(got[0], pat(16'h0001));
    stop_test();
  end
  initial
  begin
    #400000;
    err_total++;
    stop_test();
  end
endmodule // testbench
